/* File: src/sca_pkg.sv */
/*
 * Shared constants and types for the sampling-clock alignment block:
 * register offsets, field positions, reset values, ramp timing and the
 * packed state carried by the block.
 * Assumes a byte-wide register port addressed at the printed offsets.
 */
package sca_pkg;

    // Register offsets (byte-wide registers, one per address).
    localparam logic [11:0] OFS_DELAY_INV   = 12'h0_028;
    localparam logic [11:0] OFS_DELAY_CRS   = 12'h0_029;
    localparam logic [11:0] OFS_DELAY_FINE  = 12'h0_02A;
    localparam logic [11:0] OFS_RAMP_CTL    = 12'h0_02B;
    localparam logic [11:0] OFS_FLAGS_LOW   = 12'h0_02C;
    localparam logic [11:0] OFS_FLAGS_MID   = 12'h0_02D;
    localparam logic [11:0] OFS_FLAGS_HIGH  = 12'h0_02E;
    localparam logic [11:0] OFS_CLOCK_CTL   = 12'h0_030;
    localparam logic [11:0] OFS_CAL_ENABLE  = 12'h0_031;
    localparam logic [11:0] OFS_CAL_CFG     = 12'h0_032;
    localparam logic [11:0] OFS_CAL_STATUS  = 12'h0_033;
    localparam logic [11:0] OFS_CAL_RESULT  = 12'h0_034;
    localparam logic [11:0] OFS_CAL_RES_INV = 12'h0_035;

    // Field positions.
    localparam int RAMP_EN_BIT    = 0;
    localparam int RAMP_FAST_BIT  = 1;
    localparam int SEL_LSB        = 0;
    localparam int STEP_FINE_BIT  = 4;
    localparam int CAL_EN_BIT     = 0;
    localparam int DONE_BIT       = 0;
    localparam int WIN_VALID_BIT  = 1;

    // Reset values.
    localparam logic [7:0] RST_COARSE  = 8'h00;
    localparam logic [7:0] RST_FINE    = 8'h00;
    localparam logic [7:0] RST_CAL_CFG = 8'h00;
    localparam logic       RST_STEP_FINE = 1'b1;

    // Timing and geometry.
    localparam int         NUM_PHASES    = 24;
    localparam int         SEL_BITS      = 4;
    localparam logic [7:0] RAMP_LAST     = 8'hFF;  // 256 clocks per ramp step.
    localparam logic [7:0] STEP_SLOW     = 8'h01;
    localparam logic [7:0] STEP_FAST     = 8'h04;
    localparam logic [1:0] EDGES_VALID   = 2'h3;
    localparam logic [7:0] CODE_LAST     = 8'hFF;

    typedef enum logic [1:0] {
        CAL_IDLE   = 2'b00,
        CAL_SEARCH = 2'b01,
        CAL_DONE   = 2'b10
    } sca_cal_t;

    // Delay setting handed to the analog delay line.
    typedef struct packed {
        logic       invert;
        logic [7:0] coarse;
        logic [7:0] fine;
    } sca_delay_t;

    typedef struct packed {
        logic                  inv;
        logic [7:0]            coarse_tgt;
        logic [7:0]            fine;
        logic                  ramp_en;
        logic                  ramp_fast;
        logic [7:0]            coarse_now;
        logic [7:0]            ramp_cnt;
        logic [SEL_BITS-1:0]   phase_sel;
        logic                  step_fine;
        logic [NUM_PHASES-1:0] flags;
        logic [1:0]            edge_cnt;
        logic                  tap0_prev;
        logic                  sel_prev;
        logic                  capture;
        sca_cal_t              cal;
        logic                  cal_en;
        logic [7:0]            cal_cfg;
        logic                  cal_inv;
        logic [7:0]            cal_coarse;
        logic [3:0]            cal_wait;
        logic                  have_prev;
        logic                  clk_prev;
        logic                  found0;
        logic [7:0]            found0_code;
        logic                  res_inv;
        logic [7:0]            res_coarse;
        logic                  complete;
        sca_delay_t            applied;
        logic [7:0]            rdata;
    } sca_state_t;

endpackage : sca_pkg

/* File: src/sca_align.sv */
/*
 * Sampling-clock alignment: coarse delay ramp, SYSREF capture-window
 * detector with phase choice, and automatic delay calibration.
 * Assumes the analog front end supplies SYSREF sampled at each delayed
 * capture phase and the internal clock level seen at the SYSREF rise,
 * all synchronous to CLOCK, and that it applies DELAY_SET to the clock.
 */
`timescale 1ns/100ps

// Operation
// - Ramp coarse delay gradually when ramping enabled.
// - Speed: one or four steps per 256.
// - Each coarse write restarts ramp toward it.
// - Record SYSREF position as 24 phase flags.
// - Flags valid after three SYSREF rising edges.
// - Flag one marks risky phase, zero usable.
// - Edge flags 0 and 23 always read one.
// - Phase choice index selects phases 0 to 15.
// - Window step control picks coarse or fine.
// - Search delay until falling edge meets SYSREF.
// - Found setting readable in calibration result.
// - Calibrated setting stays in use afterwards.
// - Search both polarities, keep smallest coarse code.
// - Invert adds half period; 256 coarse, fine.
// - Delay changes on the fly allowed.
module sca_align #(
    parameter int NUM_PHASES = 24,
    parameter int SEL_BITS   = 4
) (
    input  wire logic                            CLOCK,
    input  wire logic                            RESET,
    input  wire logic [11:0]                     ADDR,
    input  wire logic [7:0]                      WDATA,
    input  wire logic                            WR,
    input  wire logic                            RD,
    output logic      [7:0]                      RDATA,
    input  wire logic [sca_pkg::NUM_PHASES-1:0]  SYSREF_TAPS,
    input  wire logic                            CLK_AT_SYSREF,
    output sca_pkg::sca_delay_t                  DELAY_SET,
    output logic                                 WINDOW_STEP_FINE,
    output logic                                 SYSREF_CAPTURE
);

    // The state layout is fixed in the package, so other sizes are refused.
    if (NUM_PHASES != sca_pkg::NUM_PHASES || SEL_BITS != sca_pkg::SEL_BITS) begin : g_chk
        $error("sca_align: phase count or select width not supported");
    end

    sca_pkg::sca_state_t s_reg;
    sca_pkg::sca_state_t s_next;

    // Ramp step helper: move toward the target by at most the step size.
    function automatic logic [7:0] ramp_step(input logic [7:0] now,
                                             input logic [7:0] tgt,
                                             input logic [7:0] step);
        logic [7:0] gap;
        gap = (tgt > now) ? tgt - now : now - tgt;
        if (gap <= step) begin
            ramp_step = tgt;
        end else if (tgt > now) begin
            ramp_step = now + step;
        end else begin
            ramp_step = now - step;
        end
    endfunction : ramp_step

    // Window flags as seen by software: all risky until enough edges.
    function automatic logic [NUM_PHASES-1:0] shown_flags(input sca_pkg::sca_state_t st);
        logic [NUM_PHASES-1:0] f;
        f = st.flags;
        if (st.edge_cnt != sca_pkg::EDGES_VALID) begin
            f = '1;
        end
        f[0] = 1'b1;
        f[NUM_PHASES-1] = 1'b1;
        shown_flags = f;
    endfunction : shown_flags

    // Whole next-state computation of the block.
    always_comb begin
        logic                  rise;
        logic                  sel_tap;
        logic                  hit;
        logic                  use1;
        logic [7:0]            step;
        logic [NUM_PHASES-1:0] shown;
        logic [NUM_PHASES-1:0] seen;
        rise    = 1'b0;
        seen    = '0;
        sel_tap = 1'b0;
        hit     = 1'b0;
        use1    = 1'b0;
        step    = sca_pkg::STEP_SLOW;
        shown   = shown_flags(s_reg);
        s_next  = s_reg;

        // SYSREF rise seen on the earliest tap; capture on the chosen tap.
        rise = SYSREF_TAPS[0] & ~s_reg.tap0_prev;
        s_next.tap0_prev = SYSREF_TAPS[0];
        sel_tap = SYSREF_TAPS[s_reg.phase_sel];
        s_next.sel_prev = sel_tap;
        s_next.capture  = sel_tap & ~s_reg.sel_prev;

        // A phase whose sample disagrees with its neighbour sits on the
        // SYSREF edge and so risks setup or hold; flags accumulate.
        if (rise) begin
            for (int i = 0; i < NUM_PHASES - 1; i++) begin
                if (SYSREF_TAPS[i] != SYSREF_TAPS[i+1]) begin
                    seen[i]   = 1'b1;
                    seen[i+1] = 1'b1;
                end
            end
            s_next.flags = s_reg.flags | seen;
            if (s_reg.edge_cnt != sca_pkg::EDGES_VALID) begin
                s_next.edge_cnt = s_reg.edge_cnt + 2'h1;
            end
        end

        // Coarse ramp; the slow or fast step lands once per 256 clocks.
        step = s_reg.ramp_fast ? sca_pkg::STEP_FAST : sca_pkg::STEP_SLOW;
        if (!s_reg.ramp_en) begin
            s_next.coarse_now = s_reg.coarse_tgt;
            s_next.ramp_cnt   = 8'h00;
        end else if (s_reg.coarse_now == s_reg.coarse_tgt) begin
            s_next.ramp_cnt   = 8'h00;
        end else begin
            s_next.ramp_cnt = s_reg.ramp_cnt + 8'h01;
            if (s_reg.ramp_cnt == sca_pkg::RAMP_LAST) begin
                s_next.coarse_now = ramp_step(s_reg.coarse_now, s_reg.coarse_tgt, step);
            end
        end

        // Calibration search: each code is held for cfg[3:0]+1 SYSREF edges so
        // the delay line settles before the clock level is judged.
        case (s_reg.cal)
            sca_pkg::CAL_IDLE, sca_pkg::CAL_DONE: begin
            end
            sca_pkg::CAL_SEARCH: begin
                if (rise) begin
                    if (s_reg.cal_wait < s_reg.cal_cfg[3:0]) begin
                        s_next.cal_wait = s_reg.cal_wait + 4'h1;
                    end else begin
                        s_next.cal_wait = 4'h0;
                        // Clock high then low at the SYSREF rise: its
                        // falling edge now lines up with SYSREF.
                        hit = s_reg.have_prev & s_reg.clk_prev & ~CLK_AT_SYSREF;
                        if (!s_reg.cal_inv && (hit || s_reg.cal_coarse == sca_pkg::CODE_LAST)) begin
                            s_next.found0      = hit;
                            s_next.found0_code = s_reg.cal_coarse;
                            s_next.cal_inv     = 1'b1;
                            s_next.cal_coarse  = 8'h00;
                            s_next.have_prev   = 1'b0;
                        end else if (hit || s_reg.cal_coarse == sca_pkg::CODE_LAST) begin
                            // Keep the polarity needing the smaller code.
                            use1 = hit && (!s_reg.found0 ||
                                           s_reg.cal_coarse < s_reg.found0_code);
                            if (use1) begin
                                s_next.res_inv    = 1'b1;
                                s_next.res_coarse = s_reg.cal_coarse;
                            end else if (s_reg.found0) begin
                                s_next.res_inv    = 1'b0;
                                s_next.res_coarse = s_reg.found0_code;
                            end else begin
                                s_next.res_inv    = 1'b0;
                                s_next.res_coarse = sca_pkg::RST_COARSE;
                            end
                            s_next.cal      = sca_pkg::CAL_DONE;
                            s_next.complete = 1'b1;
                            // Result becomes the working setting.
                            s_next.inv        = s_next.res_inv;
                            s_next.coarse_tgt = s_next.res_coarse;
                            s_next.coarse_now = s_next.res_coarse;
                        end else begin
                            s_next.cal_coarse = s_reg.cal_coarse + 8'h01;
                            s_next.have_prev  = 1'b1;
                            s_next.clk_prev   = CLK_AT_SYSREF;
                        end
                    end
                end
            end
            default: begin
                s_next.cal = sca_pkg::CAL_IDLE;
            end
        endcase

        // Register writes.
        if (WR) begin
            case (ADDR)
                sca_pkg::OFS_DELAY_INV: begin
                    s_next.inv = WDATA[0];
                end
                sca_pkg::OFS_DELAY_CRS: begin
                    s_next.coarse_tgt = WDATA;
                    s_next.ramp_cnt   = 8'h00;
                end
                sca_pkg::OFS_DELAY_FINE: begin
                    s_next.fine = WDATA;
                end
                sca_pkg::OFS_RAMP_CTL: begin
                    s_next.ramp_en   = WDATA[sca_pkg::RAMP_EN_BIT];
                    s_next.ramp_fast = WDATA[sca_pkg::RAMP_FAST_BIT];
                end
                sca_pkg::OFS_CLOCK_CTL: begin
                    s_next.phase_sel = WDATA[sca_pkg::SEL_LSB +: SEL_BITS];
                    s_next.step_fine = WDATA[sca_pkg::STEP_FINE_BIT];
                    // A new step size moves every phase, so start over; a
                    // rise in this same cycle still counts, as a set wins.
                    s_next.flags    = seen;
                    s_next.edge_cnt = {1'b0, rise};
                end
                sca_pkg::OFS_CAL_ENABLE: begin
                    s_next.cal_en = WDATA[sca_pkg::CAL_EN_BIT];
                    if (WDATA[sca_pkg::CAL_EN_BIT] && !s_reg.cal_en) begin
                        s_next.cal        = sca_pkg::CAL_SEARCH;
                        s_next.complete   = 1'b0;
                        s_next.cal_inv    = 1'b0;
                        s_next.cal_coarse = 8'h00;
                        s_next.cal_wait   = 4'h0;
                        s_next.have_prev  = 1'b0;
                        s_next.found0     = 1'b0;
                    end else if (!WDATA[sca_pkg::CAL_EN_BIT]) begin
                        // Abort or release; a finished result stays in use.
                        s_next.cal = sca_pkg::CAL_IDLE;
                    end
                end
                sca_pkg::OFS_CAL_CFG: begin
                    s_next.cal_cfg = WDATA;
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses answer zero.
        s_next.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                sca_pkg::OFS_DELAY_INV:   s_next.rdata = {7'h00, s_reg.inv};
                sca_pkg::OFS_DELAY_CRS:   s_next.rdata = s_reg.coarse_tgt;
                sca_pkg::OFS_DELAY_FINE:  s_next.rdata = s_reg.fine;
                sca_pkg::OFS_RAMP_CTL:    s_next.rdata = {6'h00, s_reg.ramp_fast, s_reg.ramp_en};
                sca_pkg::OFS_FLAGS_LOW:   s_next.rdata = shown[7:0];
                sca_pkg::OFS_FLAGS_MID:   s_next.rdata = shown[15:8];
                sca_pkg::OFS_FLAGS_HIGH:  s_next.rdata = shown[23:16];
                sca_pkg::OFS_CLOCK_CTL:   s_next.rdata = {3'h0, s_reg.step_fine, s_reg.phase_sel};
                sca_pkg::OFS_CAL_ENABLE:  s_next.rdata = {7'h00, s_reg.cal_en};
                sca_pkg::OFS_CAL_CFG:     s_next.rdata = s_reg.cal_cfg;
                sca_pkg::OFS_CAL_STATUS:  s_next.rdata = {6'h00,
                                              s_reg.edge_cnt == sca_pkg::EDGES_VALID,
                                              s_reg.complete};
                sca_pkg::OFS_CAL_RESULT:  s_next.rdata = s_reg.res_coarse;
                sca_pkg::OFS_CAL_RES_INV: s_next.rdata = {7'h00, s_reg.res_inv};
                default:                  s_next.rdata = 8'h00;
            endcase
        end

        // While searching, the trial code drives the delay line directly;
        // otherwise the ramped software setting does.
        if (s_next.cal == sca_pkg::CAL_SEARCH) begin
            s_next.applied = '{invert: s_next.cal_inv, coarse: s_next.cal_coarse,
                               fine: s_next.fine};
        end else begin
            s_next.applied = '{invert: s_next.inv, coarse: s_next.coarse_now,
                               fine: s_next.fine};
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            s_reg            <= '0;
            s_reg.coarse_tgt <= sca_pkg::RST_COARSE;
            s_reg.coarse_now <= sca_pkg::RST_COARSE;
            s_reg.fine       <= sca_pkg::RST_FINE;
            s_reg.cal_cfg    <= sca_pkg::RST_CAL_CFG;
            s_reg.step_fine  <= sca_pkg::RST_STEP_FINE;
            s_reg.cal        <= sca_pkg::CAL_IDLE;
            s_reg.applied    <= '{invert: 1'b0, coarse: sca_pkg::RST_COARSE,
                                  fine: sca_pkg::RST_FINE};
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs come straight from the state register.
    assign RDATA            = s_reg.rdata;
    assign DELAY_SET        = s_reg.applied;
    assign WINDOW_STEP_FINE = s_reg.step_fine;
    assign SYSREF_CAPTURE   = s_reg.capture;

endmodule : sca_align

/* File: bench/sca_align_chk.sv */
/* Port checker for the sampling-clock alignment block.
   Assumes it is bound onto sca_align and shares its single clock. */
`timescale 1ns/100ps
module sca_align_chk #(
    parameter int NUM_PHASES = 24,
    parameter int SEL_BITS   = 4
) (
    input wire logic                            CLOCK,
    input wire logic                            RESET,
    input wire logic [11:0]                     ADDR,
    input wire logic [7:0]                      WDATA,
    input wire logic                            WR,
    input wire logic                            RD,
    input wire logic [7:0]                      RDATA,
    input wire logic [sca_pkg::NUM_PHASES-1:0]  SYSREF_TAPS,
    input wire sca_pkg::sca_delay_t             DELAY_SET,
    input wire logic                            WINDOW_STEP_FINE,
    input wire logic                            SYSREF_CAPTURE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    logic       ramp_on_reg;
    logic [7:0] tgt_reg;
    logic [8:0] gap_reg;
    logic [7:0] move_up;
    logic [7:0] move_dn;
    // Mirrors of the ramp setup, and the age of the last coarse move, which
    // lets the step spacing be judged without seeing the hidden counter.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ramp_on_reg <= 1'b0;
            tgt_reg     <= 8'h00;
            gap_reg     <= 9'h000;
        end else begin
            if (WR && ADDR == sca_pkg::OFS_RAMP_CTL) ramp_on_reg <= WDATA[0];
            if (WR && ADDR == sca_pkg::OFS_DELAY_CRS) tgt_reg <= WDATA;
            if ($changed(DELAY_SET.coarse)) gap_reg <= 9'h000;
            else if (gap_reg != 9'h1FF) gap_reg <= gap_reg + 9'h001;
        end
    end
    assign move_up = DELAY_SET.coarse - tgt_reg;
    assign move_dn = tgt_reg - DELAY_SET.coarse;
    // Ramp and direct coarse behaviour.
    ramp_gap_a: assert property (ramp_on_reg && $changed(DELAY_SET.coarse)
        |-> gap_reg >= 9'h0FF) else $error("ramp step came too early");
    ramp_size_a: assert property (ramp_on_reg && $changed(DELAY_SET.coarse)
        |-> (8'(DELAY_SET.coarse - $past(DELAY_SET.coarse)) <= 8'h04)
         || (8'(($past(DELAY_SET.coarse) - DELAY_SET.coarse)) <= 8'h04))
        else $error("ramp step too large");
    ramp_stop_a: assert property (ramp_on_reg && move_up == 8'h00 && !WR
        |=> $stable(DELAY_SET.coarse)) else $error("ramp moved past target");
    direct_coarse_a: assert property (WR && ADDR == sca_pkg::OFS_DELAY_CRS
        && !ramp_on_reg && !(move_dn == 8'h00 && WDATA == tgt_reg)
        |-> ##2 DELAY_SET.coarse == $past(WDATA, 2)) else $error("coarse jump late");
    // Window detector.
    flag_low_a: assert property (RD && ADDR == sca_pkg::OFS_FLAGS_LOW
        |=> RDATA[0]) else $error("flag bit 0 low");
    flag_high_a: assert property (RD && ADDR == sca_pkg::OFS_FLAGS_HIGH
        |=> RDATA[7]) else $error("flag bit 23 low");
    flag_early_a: assert property ((WR && ADDR == sca_pkg::OFS_CLOCK_CTL)
        ##2 (RD && ADDR == sca_pkg::OFS_FLAGS_MID) |=> RDATA == 8'hFF)
        else $error("flags valid too soon");
    step_set_a: assert property (WR && ADDR == sca_pkg::OFS_CLOCK_CTL && WDATA[4]
        |-> ##[1:2] WINDOW_STEP_FINE) else $error("fine step not applied");
    capture_pulse_a: assert property (SYSREF_CAPTURE
        |-> ($past(|SYSREF_TAPS[15:0]) || $past(|SYSREF_TAPS[15:0], 2))
        ##1 !SYSREF_CAPTURE) else $error("capture pulse malformed");
    cover property (SYSREF_CAPTURE);
    cover property (ramp_on_reg && $changed(DELAY_SET.coarse));
    cover property (RD && ADDR == sca_pkg::OFS_CAL_RESULT);
endmodule : sca_align_chk

bind sca_align sca_align_chk #(.NUM_PHASES(NUM_PHASES), .SEL_BITS(SEL_BITS)) sca_align_chk_i (
    .CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SYSREF_TAPS(SYSREF_TAPS), .DELAY_SET(DELAY_SET),
    .WINDOW_STEP_FINE(WINDOW_STEP_FINE), .SYSREF_CAPTURE(SYSREF_CAPTURE));

/* File: bench/sca_sysref_src.sv */
/* Model of the external clock source: periodic SYSREF seen at the taps and
   the phase detector level. Assumes the delay setting drives the crossing. */
`timescale 1ns/100ps
module sca_sysref_src #(
    parameter int         PERIOD   = 8,
    parameter logic [7:0] HIT_NORM = 8'h05,
    parameter logic [7:0] HIT_INV  = 8'h03
) (
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire sca_pkg::sca_delay_t delay_set,
    input  wire logic [23:0]         tap_mask,
    output logic [23:0]              taps,
    output logic                     clk_at
);
    int ph_reg;
    // SYSREF runs continuously, even through reset, as calibration needs.
    always_ff @(posedge clock) begin
        ph_reg <= (ph_reg >= PERIOD - 1) ? 0 : ph_reg + 1;
    end
    // Only taps inside the mask see the high half; later taps miss it.
    assign taps = (ph_reg < PERIOD / 2) ? tap_mask : 24'h00_0000;
    // The clock reads high at the rise until the delay passes the crossing.
    assign clk_at = delay_set.invert ? (delay_set.coarse < HIT_INV)
                                     : (delay_set.coarse < HIT_NORM);
endmodule : sca_sysref_src

/* File: bench/sca_align_tb_top.sv */
/* Self-checking bench for the alignment block.
   Assumes the clock-source model and the bound port checker. */
`timescale 1ns/100ps
module sca_align_tb_top;
    logic                clock = 1'b0;
    logic                reset = 1'b1;
    logic [11:0]         addr  = 12'h000;
    logic [7:0]          wdata = 8'h00;
    logic                wr    = 1'b0;
    logic                rd    = 1'b0;
    logic [7:0]          rdata;
    logic [23:0]         taps;
    logic                clk_at;
    sca_pkg::sca_delay_t delay_set;
    logic                step_fine;
    logic                capture;
    int                  err_count = 0;
    int                  compares  = 0;

    // Ten-nanosecond clock.
    always #5 clock = ~clock;

    sca_align sca_align_i (.CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SYSREF_TAPS(taps), .CLK_AT_SYSREF(clk_at),
        .DELAY_SET(delay_set), .WINDOW_STEP_FINE(step_fine), .SYSREF_CAPTURE(capture));
    sca_sysref_src sca_sysref_src_i (.clock(clock), .reset(reset), .delay_set(delay_set),
        .tap_mask(24'h00_00FF), .taps(taps), .clk_at(clk_at));

    task automatic stop_test();
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // Writes and reads leave one idle cycle so a strobe is never set twice at once.
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask : wr_reg

    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        addr <= a;
        rd   <= 1'b1;
        tick(1);
        rd <= 1'b0;
        d = rdata;
        tick(1);
    endtask : rd_reg

    task automatic t_reset();
        check("delay", 24'(delay_set), 24'h00_0000);
        check("step", 24'(step_fine), 24'h00_0001);
        wr_reg(sca_pkg::OFS_DELAY_FINE, 8'hA5);
        wr_reg(sca_pkg::OFS_DELAY_INV, 8'h01);
        check("inv fine", 24'(delay_set), 24'h01_00A5);
    endtask : t_reset

    task automatic t_ramp();
        wr_reg(sca_pkg::OFS_DELAY_CRS, 8'h10);
        tick(1);
        check("direct", 24'(delay_set.coarse), 24'h00_0010);
        wr_reg(sca_pkg::OFS_RAMP_CTL, 8'h01);
        wr_reg(sca_pkg::OFS_DELAY_CRS, 8'h12);
        tick(250);
        check("hold", 24'(delay_set.coarse), 24'h00_0010);
        tick(20);
        check("slow1", 24'(delay_set.coarse), 24'h00_0011);
        tick(256);
        check("slow2", 24'(delay_set.coarse), 24'h00_0012);
        tick(300);
        check("stop", 24'(delay_set.coarse), 24'h00_0012);
        wr_reg(sca_pkg::OFS_RAMP_CTL, 8'h03);
        wr_reg(sca_pkg::OFS_DELAY_CRS, 8'h19);
        tick(270);
        check("fast", 24'(delay_set.coarse), 24'h00_0016);
        wr_reg(sca_pkg::OFS_DELAY_CRS, 8'h14);
        tick(270);
        check("redirect", 24'(delay_set.coarse), 24'h00_0014);
        wr_reg(sca_pkg::OFS_RAMP_CTL, 8'h00);
    endtask : t_ramp

    task automatic t_window();
        logic [7:0] d;
        int         n;
        wr_reg(sca_pkg::OFS_CLOCK_CTL, 8'h13);
        rd_reg(sca_pkg::OFS_FLAGS_MID, d);
        check("early", 24'(d), 24'h00_00FF);
        tick(40);
        rd_reg(sca_pkg::OFS_FLAGS_LOW, d);
        check("flags low", 24'(d), 24'h00_0081);
        rd_reg(sca_pkg::OFS_FLAGS_MID, d);
        check("flags mid", 24'(d), 24'h00_0001);
        rd_reg(sca_pkg::OFS_FLAGS_HIGH, d);
        check("flags high", 24'(d), 24'h00_0080);
        rd_reg(sca_pkg::OFS_CAL_STATUS, d);
        check("valid", 24'(d[1]), 24'h00_0001);
        n = 0;
        repeat (32) begin
            tick(1);
            n += int'(capture);
        end
        check("captures", 24'(n), 24'h00_0004);
        wr_reg(sca_pkg::OFS_CLOCK_CTL, 8'h0F);
        check("coarse step", 24'(step_fine), 24'h00_0000);
        n = 0;
        repeat (32) begin
            tick(1);
            n += int'(capture);
        end
        check("no capture", 24'(n), 24'h00_0000);
        wr_reg(sca_pkg::OFS_CLOCK_CTL, 8'h10);
    endtask : t_window

    task automatic t_cal();
        logic [7:0] d;
        // No converter calibration runs in this bench while the search does.
        wr_reg(sca_pkg::OFS_CAL_CFG, 8'h00);
        wr_reg(sca_pkg::OFS_CAL_ENABLE, 8'h01);
        rd_reg(sca_pkg::OFS_CAL_STATUS, d);
        check("busy", 24'(d[0]), 24'h00_0000);
        for (int i = 0; i < 600 && d[0] !== 1'b1; i++) rd_reg(sca_pkg::OFS_CAL_STATUS, d);
        check("done", 24'(d[0]), 24'h00_0001);
        rd_reg(sca_pkg::OFS_CAL_RESULT, d);
        check("result", 24'(d), 24'h00_0003);
        rd_reg(sca_pkg::OFS_CAL_RES_INV, d);
        check("result inv", 24'(d), 24'h00_0001);
        tick(100);
        check("applied", 24'({delay_set.invert, delay_set.coarse}), 24'h00_0103);
        wr_reg(sca_pkg::OFS_CAL_ENABLE, 8'h00);
        check("kept", 24'({delay_set.invert, delay_set.coarse}), 24'h00_0103);
    endtask : t_cal

    // Guard against a hang; the whole run needs under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        stop_test();
    end

    // Main sequence.
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        tick(1);
        t_reset();
        t_ramp();
        t_window();
        t_cal();
        stop_test();
    end
endmodule : sca_align_tb_top
